// File: rtl/fspr_consts.svh
`ifndef FSPR_CONSTS_SVH
`define FSPR_CONSTS_SVH
// Summary of operation
// [RULE1] Device locks down an unlocked-disabled block when write-protect falls.
// [RULE2] Device remembers prior lock state to resolve write-protect rise from locked-down.
// [RULE3] All blocks come up locked, not locked-down, after reset.
// [RULE4] Status bit 7 is one when the write engine is ready.
// [RULE5] Status bit 6 is one while a block erase is suspended.
// [RULE6] Status bit 5 is one after a failed erase.
// [RULE7] Status bit 4 is one after a failed program.
// [RULE8] Status bit 3 reports low program supply, sampled only after operations.
// [RULE9] Status bit 2 is one while a program is suspended.
// [RULE10] Status bit 1 reports an attempt on a locked block.
// [RULE11] Each partition has its own status; ready does not mean engine free.
// [RULE12] Host polls bit 7 and ignores bits 6..1 while it is zero.
// [RULE13] Bits 5 and 4 both set mean an improper command sequence.
// [RULE14] Host masks reserved status and extended status bits.
// [RULE15] Extended status bit 7 shows page-buffer program command acceptance.
// [RULE16] Host reissues page-buffer command until accepted, before loading data; the host gives up after POLL_LIMIT reissues and loads no data.
// [RULE17] Layout field bits 10..8 map planes to partitions (codes 000,001,010,100).
// [RULE18] Codes 110,101,011 give three partitions; 111 gives four.
// [RULE19] Code 000 forbids simultaneous read-while-write.
// [RULE20] Layout field resets to 001 bottom-parameter or 100 top-parameter.
// [RULE21] Host masks layout bits 15..11 and 7..0.
// [RULE22] Chip erase and one-time program cannot be suspended.
// [RULE23] Status reads drive the addressed partition's word, reserved bits zero.

// ----------------------------------------
// Commands
// ----------------------------------------
`define FSPR_CMD_READ_STATUS 16'h0070
`define FSPR_CMD_CLEAR_STATUS 16'h0050
`define FSPR_CMD_BUF_PROGRAM 16'h00e8
`define FSPR_CMD_CONFIRM 16'h00d0
`define FSPR_CMD_READ_ARRAY 16'h00ff
`define FSPR_CMD_READ_ID 16'h0090
`define FSPR_CMD_SET_LAYOUT 16'h0060
`define FSPR_CMD_LAYOUT_CONFIRM 16'h0004

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define FSPR_SR_READY_BIT 7
`define FSPR_SR_ERASE_ERR_BIT 5
`define FSPR_SR_PROG_ERR_BIT 4
`define FSPR_SR_MASK 16'h00fe
`define FSPR_XSR_ACCEPT_BIT 7
`define FSPR_XSR_MASK 16'h0080
`define FSPR_PCR_MASK 16'h0700
`define FSPR_PCR_LSB 8
`define FSPR_PCR_ID_ADDR 22'h000006

// ----------------------------------------
// Bus timing, cycles of 10 ns
// ----------------------------------------
`define FSPR_T_STROBE_NS 70
`define FSPR_T_STROBE_CYC ((`FSPR_T_STROBE_NS + 9) / 10)
`define FSPR_T_RECOVER_NS 30
`define FSPR_T_RECOVER_CYC ((`FSPR_T_RECOVER_NS + 9) / 10)
`endif

// File: rtl/fspr_pkg.sv
package fspr_pkg;
  // Host orders
  typedef enum logic [2:0] {
    FSPR_OP_STATUS = 3'h0,
    FSPR_OP_BUF_PROGRAM = 3'h1,
    FSPR_OP_READ_LAYOUT = 3'h2,
    FSPR_OP_WRITE_LAYOUT = 3'h3,
    FSPR_OP_CLEAR_STATUS = 3'h4
  } fspr_op_type;

  // Bus sequencer, Gray from IDLE through DONE; DONE back to IDLE flips all three bits
  typedef enum logic [2:0] {
    FSPR_IDLE = 3'b000,
    FSPR_WR_CMD = 3'b001,
    FSPR_WR_GAP = 3'b011,
    FSPR_RD_CMD = 3'b010,
    FSPR_RD_DATA = 3'b110,
    FSPR_DONE = 3'b111
  } fspr_state_type;
endpackage : fspr_pkg

// File: rtl/fspr_host.sv
`timescale 1ns/1ps
`include "fspr_consts.svh"
// ----------------------------------------
// Flash status and layout host controller
// ----------------------------------------
module fspr_host #(
  parameter int ADDR_W = 22,
  parameter int POLL_LIMIT = 4095
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fspr_pkg::fspr_op_type req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [2:0] req_layout,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_engine_ready,
  output logic [6:0] rsp_status_bits,
  output logic rsp_sequence_error,
  output logic rsp_buffer_accept,
  output logic [2:0] rsp_plane_grouping_code,
  output logic rsp_timeout,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  input wire logic [15:0] flash_dq_in,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  fspr_pkg::fspr_state_type state_q, state_d;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic [3:0] tcnt_q;
  logic [11:0] polls_q;
  logic [1:0] wr_idx_q;
  logic [1:0] wr_cnt_q;
  fspr_pkg::fspr_op_type op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0] layout_q;
  logic [15:0] word_d;
  logic [15:0] cmd_word;
  logic timer_done, status_word, ready_bit, poll_more;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // The write count per order: layout write is two cycles with data on address
  assign req_ready = (state_q == fspr_pkg::FSPR_IDLE);
  assign timer_done = (tcnt_q == 4'h0);
  assign status_word = (op_q == fspr_pkg::FSPR_OP_STATUS) || (op_q == fspr_pkg::FSPR_OP_BUF_PROGRAM);
  assign ready_bit = dq_s2_q[`FSPR_SR_READY_BIT];
  // Buffer command reports acceptance on extended bit 7; status polls wait on bit 7
  assign poll_more = status_word && !ready_bit && (polls_q != POLL_LIMIT[11:0]); // [RULE12] [RULE16]
  assign cmd_word = (op_q == fspr_pkg::FSPR_OP_BUF_PROGRAM) ? `FSPR_CMD_BUF_PROGRAM :
    (op_q == fspr_pkg::FSPR_OP_READ_LAYOUT) ? `FSPR_CMD_READ_ID :
    (op_q == fspr_pkg::FSPR_OP_CLEAR_STATUS) ? `FSPR_CMD_CLEAR_STATUS :
    (op_q == fspr_pkg::FSPR_OP_WRITE_LAYOUT && wr_idx_q != 2'h0) ? `FSPR_CMD_LAYOUT_CONFIRM :
    (op_q == fspr_pkg::FSPR_OP_WRITE_LAYOUT) ? `FSPR_CMD_SET_LAYOUT : `FSPR_CMD_READ_STATUS;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Each order writes its command cycles, then reads one word, again on each busy poll, unless it is write-only
  always_comb begin
    state_d = state_q;
    case (state_q)
      fspr_pkg::FSPR_IDLE: begin
        if (req_valid) begin
          state_d = fspr_pkg::FSPR_WR_CMD;
        end
      end
      fspr_pkg::FSPR_WR_CMD: begin
        if (timer_done) begin
          state_d = fspr_pkg::FSPR_WR_GAP;
        end
      end
      fspr_pkg::FSPR_WR_GAP: begin
        if (timer_done && wr_idx_q != wr_cnt_q) begin
          state_d = fspr_pkg::FSPR_WR_CMD;
        end else if (timer_done && (op_q == fspr_pkg::FSPR_OP_CLEAR_STATUS)) begin
          state_d = fspr_pkg::FSPR_DONE;
        end else if (timer_done) begin
          state_d = fspr_pkg::FSPR_RD_CMD;
        end
      end
      fspr_pkg::FSPR_RD_CMD: begin
        if (timer_done) begin
          state_d = fspr_pkg::FSPR_RD_DATA;
        end
      end
      // A refused buffer command is written again before the next look at its flag
      fspr_pkg::FSPR_RD_DATA: begin
        if (timer_done && poll_more && (op_q == fspr_pkg::FSPR_OP_BUF_PROGRAM)) begin
          state_d = fspr_pkg::FSPR_WR_CMD; // [RULE16]
        end else if (timer_done && poll_more) begin
          state_d = fspr_pkg::FSPR_RD_CMD;
        end else if (timer_done) begin
          state_d = fspr_pkg::FSPR_DONE;
        end
      end
      fspr_pkg::FSPR_DONE: begin
        state_d = fspr_pkg::FSPR_IDLE;
      end
      default: begin
        state_d = fspr_pkg::FSPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= fspr_pkg::FSPR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Data bus from the flash is asynchronous to us, so two stages first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ----------------------------------------
  // Strobe timer and counters
  // ----------------------------------------
  // Read phase holds OE two extra cycles to cover the input synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tcnt_q <= 4'h0;
    end else if (state_d != state_q && (state_d == fspr_pkg::FSPR_WR_GAP)) begin
      tcnt_q <= 4'(`FSPR_T_RECOVER_CYC - 1);
    end else if (state_d != state_q && (state_d == fspr_pkg::FSPR_RD_DATA)) begin
      tcnt_q <= 4'(`FSPR_T_STROBE_CYC + 1);
    end else if (state_d != state_q) begin
      tcnt_q <= 4'(`FSPR_T_STROBE_CYC - 1);
    end else if (!timer_done) begin
      tcnt_q <= tcnt_q - 4'h1;
    end
  end

  // Latch the order and count write cycles and polls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q <= fspr_pkg::FSPR_OP_STATUS;
      addr_q <= '0;
      layout_q <= 3'h0;
      wr_idx_q <= 2'h0;
      wr_cnt_q <= 2'h0;
      polls_q <= 12'h000;
    end else if (state_q == fspr_pkg::FSPR_IDLE && req_valid) begin
      op_q <= req_op;
      addr_q <= req_addr;
      layout_q <= req_layout;
      wr_idx_q <= 2'h0;
      wr_cnt_q <= (req_op == fspr_pkg::FSPR_OP_WRITE_LAYOUT) ? 2'h1 : 2'h0;
      polls_q <= 12'h000;
    end else begin
      if (state_q == fspr_pkg::FSPR_WR_GAP && state_d == fspr_pkg::FSPR_WR_CMD) begin
        wr_idx_q <= wr_idx_q + 2'h1;
      end
      if (state_q == fspr_pkg::FSPR_RD_DATA && (state_d == fspr_pkg::FSPR_RD_CMD || state_d == fspr_pkg::FSPR_WR_CMD)) begin
        polls_q <= polls_q + 12'h001;
      end
    end
  end

  // ----------------------------------------
  // Flash pins
  // ----------------------------------------
  // Layout code travels on address bits during the write, read back via identifier space
  always_comb begin
    word_d = addr_q[15:0];
    if (op_q == fspr_pkg::FSPR_OP_WRITE_LAYOUT) begin
      word_d = 16'({layout_q, 8'h00}); // [RULE17] [RULE18]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      flash_dq_out <= cmd_word;
      flash_dq_oe_n <= !(state_d == fspr_pkg::FSPR_WR_CMD || state_d == fspr_pkg::FSPR_WR_GAP);
      flash_we_n <= !(state_d == fspr_pkg::FSPR_WR_CMD);
      flash_oe_n <= !(state_d == fspr_pkg::FSPR_RD_DATA);
      flash_ce_n <= !(state_d == fspr_pkg::FSPR_WR_CMD || state_d == fspr_pkg::FSPR_RD_DATA);
      if (op_q == fspr_pkg::FSPR_OP_WRITE_LAYOUT) begin
        flash_addr <= ADDR_W'(word_d);
      end else if (op_q == fspr_pkg::FSPR_OP_READ_LAYOUT) begin
        flash_addr <= addr_q | ADDR_W'(`FSPR_PCR_ID_ADDR);
      end else begin
        flash_addr <= addr_q;
      end
    end
  end

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // Reserved bits are masked before anything reaches the user
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_engine_ready <= 1'b0;
      rsp_status_bits <= 7'h00;
      rsp_sequence_error <= 1'b0;
      rsp_buffer_accept <= 1'b0;
      rsp_plane_grouping_code <= 3'h0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= (state_q == fspr_pkg::FSPR_DONE);
      if (state_q == fspr_pkg::FSPR_RD_DATA && timer_done) begin
        rsp_engine_ready <= ready_bit; // [RULE11]
        // Status bits 6..1 are meaningless while busy, so they read zero then
        rsp_status_bits <= ready_bit ? 7'((dq_s2_q & `FSPR_SR_MASK) >> 1) : 7'h00; // [RULE12] [RULE14]
        rsp_sequence_error <= ready_bit && dq_s2_q[`FSPR_SR_ERASE_ERR_BIT] && dq_s2_q[`FSPR_SR_PROG_ERR_BIT];
        rsp_buffer_accept <= (op_q == fspr_pkg::FSPR_OP_BUF_PROGRAM) && |(dq_s2_q & `FSPR_XSR_MASK); // [RULE16]
        rsp_plane_grouping_code <= 3'((dq_s2_q & `FSPR_PCR_MASK) >> `FSPR_PCR_LSB); // [RULE21]
        rsp_timeout <= status_word && !ready_bit;
      end
    end
  end
endmodule : fspr_host

// File: verification/fspr_host_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Answer and bus checks at the host ports
// ----------------------------------------
module fspr_host_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rsp_valid,
  input wire logic rsp_engine_ready,
  input wire logic [6:0] rsp_status_bits,
  input wire logic rsp_sequence_error,
  input wire logic rsp_timeout,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_dq_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Flags read while busy are untrusted, so they must be hidden
  a_busy_bits_zero: assert property (rsp_valid && !rsp_engine_ready |-> rsp_status_bits == 7'h00)
    else $error("status bits shown while busy");
  a_seq_err_pair: assert property (
    rsp_valid |-> rsp_sequence_error == (rsp_engine_ready && rsp_status_bits[4:3] == 2'b11))
    else $error("sequence error flag wrong");
  a_timeout_busy: assert property (rsp_valid && rsp_timeout |-> !rsp_engine_ready)
    else $error("timeout reported with engine ready");
  a_answer_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
  // Host must release the data bus while the device drives it
  a_read_bus_free: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n && !flash_ce_n)
    else $error("bus contention on read");
  a_write_strobe: assert property (
    $fell(flash_we_n) |-> (!flash_we_n && !flash_dq_oe_n && !flash_ce_n)[*7])
    else $error("write strobe too short");
  cover property (rsp_valid && rsp_timeout);
  cover property (rsp_valid && rsp_sequence_error);
  cover property (rsp_valid && rsp_engine_ready);
endmodule : fspr_host_chk

bind fspr_host fspr_host_chk chk_u (.*);

// File: verification/fspr_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural flash, one partition
// ----------------------------------------
module fspr_flash_model #(
  parameter logic [2:0] LAYOUT_RST = 3'h1
) (
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [7:0] stat_word,
  input wire logic [7:0] busy_n,
  input wire logic accept,
  input wire logic wp,
  output logic [7:0] n_buf,
  output logic [15:0] dq
);
  logic [1:0] mode = 2'h0;
  logic [2:0] layout = LAYOUT_RST; // Bottom parameter default
  logic pend = 1'b0;
  logic clr = 1'b0;
  logic abort = 1'b0;
  logic [1:0] lock = 2'b01; // Locked, not locked-down, whatever wp is
  logic from_disable = 1'b0;
  logic [7:0] bufs = 8'h00;
  int polls = 0;
  logic [15:0] rd;
  logic [5:0] flags;
  logic [15:0] last = 16'h0;
  wire ready = polls > busy_n; // Per partition, busy for busy_n polls
  assign n_buf = bufs;
  // Commands latch on the rising write strobe
  always @(posedge flash_we_n) begin
    case (flash_dq_out[7:0])
      8'h70: begin mode = 2'h1; polls = 0; end
      8'h50: begin clr = 1'b1; abort = 1'b0; end
      8'he8: begin
        mode = 2'h2;
        clr = 1'b0;
        bufs = bufs + 8'h01;
        if (lock[0]) abort = 1'b1; // Program on a locked block aborts
      end
      8'h90: mode = 2'h3;
      8'h04: if (pend) layout = flash_addr[10:8];
      default: mode = 2'h0; // Suspend and unknown orders are refused
    endcase
    pend = flash_dq_out[7:0] == 8'h60;
  end
  // Write-protect edges; leaving locked-down depends on the state before it
  always @(wp) begin
    if (wp) begin
      if (lock == 2'b11) lock = from_disable ? 2'b10 : 2'b11;
    end else begin
      from_disable = lock == 2'b10;
      if (lock[1]) lock = 2'b11; // Disabled lock-down snaps back locked-down
    end
  end
  // Each status read counts as one poll
  always @(negedge flash_oe_n) if (mode == 2'h1) polls = polls + 1;
  // Busy reads carry junk flags, a careless host would show them
  assign flags = clr ? 6'h00 : stat_word[6:1] | {5'h00, abort};
  assign rd = mode == 2'h1 ? {8'h00, ready, ready ? flags : 6'h15, 1'b0}
    : mode == 2'h2 ? {8'h00, accept, 7'h00}
    : (mode == 2'h3 && flash_addr[7:0] == 8'h06) ? {5'h00, layout, 8'h00} : 16'h0000;
  always @(posedge flash_oe_n) last = rd;
  assign dq = (!flash_ce_n && !flash_oe_n) ? rd : ~last; // Released bus shows no stale data
endmodule : fspr_flash_model

// File: verification/fspr_host_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller bench
// ----------------------------------------
module fspr_host_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  fspr_pkg::fspr_op_type req_op = fspr_pkg::FSPR_OP_STATUS;
  logic [21:0] req_addr = 22'h0;
  logic [2:0] req_layout = 3'h0;
  logic req_ready, rsp_valid, rsp_engine_ready, rsp_sequence_error, rsp_buffer_accept, rsp_timeout;
  logic [6:0] rsp_status_bits;
  logic [2:0] rsp_code;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic [7:0] stat_word = 8'h0;
  logic [7:0] s;
  logic [7:0] busy_n = 8'h00;
  logic wp = 1'b0;
  logic [7:0] n_buf;
  int exp_q[$];
  logic accept = 1'b0;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  fspr_host #(.POLL_LIMIT(8)) dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_layout(req_layout), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_engine_ready(rsp_engine_ready), .rsp_status_bits(rsp_status_bits), .rsp_sequence_error(rsp_sequence_error),
    .rsp_buffer_accept(rsp_buffer_accept), .rsp_plane_grouping_code(rsp_code), .rsp_timeout(rsp_timeout),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  fspr_flash_model mdl_u (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .stat_word(stat_word), .busy_n(busy_n), .accept(accept),
    .wp(wp), .n_buf(n_buf), .dq(flash_dq_in));
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // One order, held until taken, then a bounded wait for the answer
  task do_op(input fspr_pkg::fspr_op_type op, input logic [2:0] code);
    int k;
    req_valid <= 1'b1;
    req_op <= op;
    req_layout <= code;
    req_addr <= {11'($urandom), code, 8'h00};
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++) @(posedge sys_clk);
    check(16'(k < 3000), 16'h1);
  endtask : do_op
  initial begin
    void'($urandom(72));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    exp_q.push_back(1);
    do_op(fspr_pkg::FSPR_OP_READ_LAYOUT, 3'h0);
    check(16'(rsp_code), 16'(exp_q.pop_front()));
    for (int c = 0; c < 8; c++) begin
      do_op(fspr_pkg::FSPR_OP_WRITE_LAYOUT, c[2:0]);
      exp_q.push_back(c);
      do_op(fspr_pkg::FSPR_OP_READ_LAYOUT, 3'h0);
      check(16'(rsp_code), 16'(exp_q.pop_front()));
    end
    // Ready after a few busy polls, flags passed through
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 8'h30 : 8'($urandom);
      stat_word <= s;
      busy_n <= 8'(i % 4);
      do_op(fspr_pkg::FSPR_OP_STATUS, 3'h0);
      check({rsp_engine_ready, rsp_status_bits[6]}, 16'h3);
      check(16'(rsp_status_bits[5:0]), 16'(s[6:1]));
      check(16'(rsp_sequence_error), 16'(s[5] & s[4]));
    end
    busy_n <= 8'h14;
    do_op(fspr_pkg::FSPR_OP_STATUS, 3'h0);
    check({rsp_timeout, rsp_engine_ready, rsp_status_bits}, {2'b10, 7'h00});
    for (int i = 0; i < 2; i++) begin
      accept <= i[0];
      do_op(fspr_pkg::FSPR_OP_BUF_PROGRAM, 3'h0);
      check(16'(rsp_buffer_accept), 16'(i[0]));
      // A refused command is written once per look: poll limit plus one, then one more
      check(16'(n_buf), 16'(9 + i));
    end
    busy_n <= 8'h00;
    wp <= 1'b1;
    do_op(fspr_pkg::FSPR_OP_STATUS, 3'h0);
    check(16'(rsp_status_bits[0]), 16'h1);
    wp <= 1'b0;
    do_op(fspr_pkg::FSPR_OP_CLEAR_STATUS, 3'h0);
    do_op(fspr_pkg::FSPR_OP_STATUS, 3'h0);
    check(16'(rsp_status_bits), 16'h40);
    wrap_up();
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      wrap_up();
    end
  end
endmodule : fspr_host_test
